// ==== ccp_pwm_mode_unit.sv ====
// capture/compare/modulation unit with apb register access
`default_nettype none
module ccp_pwm_mode_unit
    import ccp_pwm_pkg::*;
#(
    parameter int CMP_W = 16
) (
    // clock and reset
    input  wire logic              mclk,
    input  wire logic              arst_n,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [DATA_W-1:0] pwdata,
    output var  logic [DATA_W-1:0] prdata,
    output var  logic              pready,
    output var  logic              pslverr,
    // system
    input  wire logic              sleep,
    input  wire logic [CMP_W-1:0]  cmp_timer,
    // capture input pin
    input  wire logic              capture_pin,
    // unit output pin
    output var  logic              unit_output_pin,
    output var  logic              unit_output_oe,
    output var  logic              unit_match_flag,
    output var  logic              conv_trigger
);
    if (CMP_W != 16) begin : g_w
        $error("compare width must be 16");
    end

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    function automatic logic is_pwm(input logic [3:0] m);
        is_pwm = (m[3:2] == 2'b11);
    endfunction : is_pwm

    apb_req_t   req;
    logic       acc;
    logic       wr;
    logic       mapped;
    logic [7:0] unit_control;
    logic [7:0] duty_byte;
    logic [7:0] active_duty_buffer;
    logic [1:0] duty_latch;
    logic [7:0] unit_timer_assign;
    logic [7:0] period_limit;
    logic [7:0] period_timer_control;
    logic [7:0] period_timer_count;
    logic       pin_direction_bit;
    logic       converter_trigger_source;
    logic [1:0] phase;
    logic [3:0] prescale_cnt;
    logic [3:0] capt_cnt;
    logic       capt_level;
    logic       capt_prev;
    logic       cmp_prev;
    logic       out_latch;
    logic       flag_clr;
    logic [3:0] mode;
    logic [1:0] timer_prescale_select;
    logic       timer_run;
    logic       pwm_on;
    logic       off;
    logic       inst_end;
    logic       pre_wrap;
    logic       tick;
    logic       period_end;
    logic [1:0] base_low;
    logic [9:0] time_base;
    logic [9:0] active_duty;
    logic       duty_hit;
    logic       capt_edge;
    logic       capt_fire;
    logic       cmp_hit;
    logic       cmp_event;
    logic [7:0] next_rdata;

    assign req         = '{paddr: paddr, pwrite: pwrite, pwdata: pwdata};
    assign acc         = psel & penable & pready;
    assign wr          = acc & req.pwrite;
    assign mode        = unit_control[CTL_MODE_POS +: 4];
    assign timer_prescale_select = period_timer_control[TCTL_PRE_POS +: 2];
    assign timer_run   = period_timer_control[TCTL_RUN_POS];
    assign pwm_on      = is_pwm(mode);
    assign off         = (mode == MODE_OFF);
    assign flag_clr    = wr & hit(req.paddr, OFF_STATUS) & req.pwdata[STAT_FLAG_POS];

    // ---------------- apb handshake: one wait state per access ----------------
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            pready <= 1'b0;
        end else begin
            pready <= psel & penable & ~pready;
        end
    end

    always_comb begin
        mapped     = 1'b1;
        next_rdata = 8'h00;
        case (req.paddr)
            OFF_UNIT_CONTROL:  next_rdata = unit_control;
            OFF_DUTY_BYTE:     next_rdata = duty_byte;
            OFF_ACTIVE_DUTY:   next_rdata = active_duty_buffer;
            OFF_TIMER_ASSIGN:  next_rdata = unit_timer_assign;
            OFF_PERIOD_LIMIT:  next_rdata = period_limit;
            OFF_TIMER_CONTROL: next_rdata = period_timer_control;
            OFF_TIMER_COUNT:   next_rdata = period_timer_count;
            OFF_STATUS:        next_rdata = {6'h00, out_latch, unit_match_flag};
            OFF_PIN_CONFIG:    next_rdata = {6'h00, converter_trigger_source,
                                             pin_direction_bit};
            default:           mapped     = 1'b0;
        endcase
    end

    // read data and error are loaded with the wait state, valid with pready
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            prdata  <= '0;
            pslverr <= 1'b0;
        end else if (psel & penable & ~pready) begin
            prdata  <= {24'h000000, next_rdata};
            pslverr <= ~mapped;
        end else begin
            prdata  <= '0;
            pslverr <= 1'b0;
        end
    end

    // ---------------- software registers ----------------
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            unit_control <= RST_UNIT_CONTROL;
        end else if (wr & hit(req.paddr, OFF_UNIT_CONTROL)) begin
            unit_control <= {2'b00, req.pwdata[5:0]};
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            unit_timer_assign        <= RST_BYTE;
            period_limit             <= RST_PERIOD_LIMIT;
            period_timer_control     <= RST_BYTE;
            pin_direction_bit        <= RST_PIN_DIRECTION;
            converter_trigger_source <= 1'b0;
        end else if (wr) begin
            if (hit(req.paddr, OFF_TIMER_ASSIGN)) begin
                unit_timer_assign <= req.pwdata[7:0];
            end
            if (hit(req.paddr, OFF_PERIOD_LIMIT)) begin
                period_limit <= req.pwdata[7:0];
            end
            if (hit(req.paddr, OFF_TIMER_CONTROL)) begin
                // postscale bits are stored but never reach the period logic
                period_timer_control <= {1'b0, req.pwdata[6:0]};
            end
            if (hit(req.paddr, OFF_PIN_CONFIG)) begin
                pin_direction_bit        <= req.pwdata[PCFG_DIR_POS];
                converter_trigger_source <= req.pwdata[PCFG_TRIG_POS];
            end
        end
    end

    // ---------------- period timer and prescaler ----------------
    assign inst_end = (phase == PHASE_LAST);

    // ratio 1, 4 or 16 instruction cycles per timer step
    always_comb begin
        case (timer_prescale_select)
            PRE_DIV1: pre_wrap = 1'b1;
            PRE_DIV4: pre_wrap = (prescale_cnt[1:0] == 2'h3);
            default:  pre_wrap = (prescale_cnt == 4'hf);
        endcase
    end

    // sleep stops every counter, so the unit resumes where it stopped
    assign tick       = timer_run & ~sleep & inst_end & pre_wrap;
    assign period_end = tick & (period_timer_count == period_limit);

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            phase <= 2'h0;
        end else if (~sleep) begin
            phase <= phase + 2'h1;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            prescale_cnt <= 4'h0;
        end else if (~timer_run) begin
            prescale_cnt <= 4'h0;
        end else if (~sleep & inst_end) begin
            prescale_cnt <= prescale_cnt + 4'h1;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            period_timer_count <= RST_BYTE;
        end else if (wr & hit(req.paddr, OFF_TIMER_COUNT)) begin
            period_timer_count <= req.pwdata[7:0];
        end else if (period_end) begin
            period_timer_count <= 8'h00;
        end else if (tick) begin
            period_timer_count <= period_timer_count + 8'h01;
        end
    end

    // ---------------- modulation time base ----------------
    always_comb begin
        case (timer_prescale_select)
            PRE_DIV1: base_low = phase;
            PRE_DIV4: base_low = prescale_cnt[1:0];
            default:  base_low = prescale_cnt[3:2];
        endcase
    end

    // with limit 255 every one of the 1024 duty values is reachable
    assign time_base   = {period_timer_count, base_low};
    assign active_duty = {active_duty_buffer, duty_latch};
    // a duty beyond the period never matches, so the pin keeps its level
    assign duty_hit    = pwm_on & timer_run & ~sleep & (time_base == active_duty);

    // ---------------- capture input ----------------
    ccp_pin_sync #(
        .RESET_LEVEL (1'b0)
    ) u_capt_sync (
        .mclk   (mclk),
        .arst_n (arst_n),
        .pin_in (capture_pin),
        .level  (capt_level)
    );

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            capt_prev <= 1'b0;
        end else if (~sleep) begin
            capt_prev <= capt_level;
        end
    end

    assign capt_edge = ~sleep & ((mode == MODE_CAPT_FALL) ? (capt_prev & ~capt_level)
                                                          : (~capt_prev & capt_level));

    always_comb begin
        case (mode)
            MODE_CAPT_FALL,
            MODE_CAPT_RISE:   capt_fire = capt_edge;
            MODE_CAPT_RISE4:  capt_fire = capt_edge &
                                          (capt_cnt[1:0] == 2'(CAPT_DIV4_LAST));
            MODE_CAPT_RISE16: capt_fire = capt_edge &
                                          (capt_cnt == 4'(CAPT_DIV16_LAST));
            default:          capt_fire = 1'b0;
        endcase
    end

    // edge prescaler is not cleared by a mode change, only by the off code
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            capt_cnt <= 4'h0;
        end else if (off) begin
            capt_cnt <= 4'h0;
        end else if (~sleep & capt_edge & (mode[3:2] == 2'b01)) begin
            capt_cnt <= capt_cnt + 4'h1;
        end
    end

    // ---------------- compare ----------------
    assign cmp_hit = (cmp_timer == {active_duty_buffer, duty_byte});
    // act once per match, not on every cycle the match persists
    assign cmp_event = ~sleep & cmp_hit & ~cmp_prev &
                       ((mode == MODE_CMP_TOGGLE) | (mode[3:2] == 2'b10));

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cmp_prev <= 1'b0;
        end else if (~sleep) begin
            cmp_prev <= cmp_hit;
        end
    end

    // ---------------- duty byte and active buffer ----------------
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            duty_byte          <= RST_BYTE;
            active_duty_buffer <= RST_BYTE;
            duty_latch         <= 2'h0;
        end else begin
            if (wr & hit(req.paddr, OFF_DUTY_BYTE)) begin
                duty_byte <= req.pwdata[7:0];
            end
            if (wr & hit(req.paddr, OFF_ACTIVE_DUTY) & ~pwm_on) begin
                active_duty_buffer <= req.pwdata[7:0];
            end
            if (off) begin
                duty_latch <= 2'h0;
            end else if (pwm_on & period_end) begin
                active_duty_buffer <= duty_byte;
                duty_latch <= unit_control[CTL_DUTY_LO_POS +: 2];
            end else if (capt_fire) begin
                {active_duty_buffer, duty_byte} <= cmp_timer;
            end
        end
    end

    // ---------------- output latch ----------------
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            out_latch <= 1'b0;
        end else if (off) begin
            out_latch <= 1'b0;
        end else if (pwm_on) begin
            if (period_end) begin
                // zero duty never raises the pin
                out_latch <= ({duty_byte, unit_control[5:4]} != 10'h000);
            end else if (duty_hit) begin
                out_latch <= 1'b0;
            end
        end else if (cmp_event) begin
            case (mode)
                MODE_CMP_SET:    out_latch <= 1'b1;
                MODE_CMP_CLEAR:  out_latch <= 1'b0;
                MODE_CMP_TOGGLE: out_latch <= ~out_latch;
                default:         out_latch <= out_latch;
            endcase
        end
    end

    // ---------------- flag, trigger and pins ----------------
    // a new event in the clearing cycle keeps the flag set
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            unit_match_flag <= 1'b0;
        end else if (capt_fire | cmp_event) begin
            unit_match_flag <= 1'b1;
        end else if (flag_clr) begin
            unit_match_flag <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            conv_trigger <= 1'b0;
        end else begin
            conv_trigger <= cmp_event & (mode == MODE_CMP_TRIG) &
                            converter_trigger_source;
        end
    end

    // pin level holds through sleep because out_latch is frozen there
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            unit_output_pin <= 1'b0;
            unit_output_oe  <= 1'b0;
        end else begin
            unit_output_pin <= out_latch & ~duty_hit;
            unit_output_oe  <= ~pin_direction_bit;
        end
    end
endmodule : ccp_pwm_mode_unit
`default_nettype wire

// ==== ccp_pwm_pkg.sv ====
// constants, types and register map of the capture/compare/modulation unit
`default_nettype none
package ccp_pwm_pkg;
    localparam int          ADDR_W              = 8;
    localparam int          DATA_W              = 32;
    // register byte offsets
    localparam logic [7:0]  OFF_UNIT_CONTROL    = 8'h00;
    localparam logic [7:0]  OFF_DUTY_BYTE       = 8'h04;
    localparam logic [7:0]  OFF_ACTIVE_DUTY     = 8'h08;
    localparam logic [7:0]  OFF_TIMER_ASSIGN    = 8'h0c;
    localparam logic [7:0]  OFF_PERIOD_LIMIT    = 8'h10;
    localparam logic [7:0]  OFF_TIMER_CONTROL   = 8'h14;
    localparam logic [7:0]  OFF_TIMER_COUNT     = 8'h18;
    localparam logic [7:0]  OFF_STATUS          = 8'h1c;
    localparam logic [7:0]  OFF_PIN_CONFIG      = 8'h20;
    // reset values
    localparam logic [7:0]  RST_UNIT_CONTROL    = 8'h00;
    localparam logic [7:0]  RST_BYTE            = 8'h00;
    localparam logic [7:0]  RST_PERIOD_LIMIT    = 8'hff;
    localparam logic        RST_PIN_DIRECTION   = 1'b1;
    // unit_control fields
    localparam int          CTL_DUTY_LO_POS     = 4;
    localparam int          CTL_MODE_POS        = 0;
    // period_timer_control fields
    localparam int          TCTL_POST_POS       = 3;
    localparam int          TCTL_RUN_POS        = 2;
    localparam int          TCTL_PRE_POS        = 0;
    // status / pin_config fields
    localparam int          STAT_FLAG_POS       = 0;
    localparam int          STAT_PIN_POS        = 1;
    localparam int          PCFG_DIR_POS        = 0;
    localparam int          PCFG_TRIG_POS       = 1;
    // prescale select codes
    localparam logic [1:0]  PRE_DIV1            = 2'h0;
    localparam logic [1:0]  PRE_DIV4            = 2'h1;
    // instruction cycle = 4 oscillator periods
    localparam logic [1:0]  PHASE_LAST          = 2'h3;
    localparam int          CAPT_DIV4_LAST      = 3;
    localparam int          CAPT_DIV16_LAST     = 15;

    typedef enum logic [3:0] {
        MODE_OFF         = 4'b0000,
        MODE_CMP_TOGGLE  = 4'b0010,
        MODE_CAPT_FALL   = 4'b0100,
        MODE_CAPT_RISE   = 4'b0101,
        MODE_CAPT_RISE4  = 4'b0110,
        MODE_CAPT_RISE16 = 4'b0111,
        MODE_CMP_SET     = 4'b1000,
        MODE_CMP_CLEAR   = 4'b1001,
        MODE_CMP_SOFT    = 4'b1010,
        MODE_CMP_TRIG    = 4'b1011,
        MODE_PWM         = 4'b1100
    } unit_mode_t;

    typedef struct packed {
        logic [ADDR_W-1:0] paddr;
        logic              pwrite;
        logic [DATA_W-1:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [7:0] duty_byte;
        logic [1:0] duty_low_bits;
    } duty_t;
endpackage : ccp_pwm_pkg
`default_nettype wire

// ==== ccp_pin_sync.sv ====
// three-stage synchroniser; output moves once the last two stages agree
`default_nettype none
module ccp_pin_sync #(
    parameter logic RESET_LEVEL = 1'b0
) (
    // clock and reset
    input  wire logic mclk,
    input  wire logic arst_n,
    // level in and out
    input  wire logic pin_in,
    output var  logic level
);
    logic s1;
    logic s2;
    logic s3;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            s1 <= RESET_LEVEL;
            s2 <= RESET_LEVEL;
            s3 <= RESET_LEVEL;
        end else begin
            s1 <= pin_in;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // s1 feeds s2 only; a single-cycle disagreement is filtered out
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            level <= RESET_LEVEL;
        end else if (s2 == s3) begin
            level <= s3;
        end
    end
endmodule : ccp_pin_sync
`default_nettype wire

// ==== ccp_pwm_mode_unit_assertions.sv ====
// port-level checks for the modulation unit, bound into every instance
`default_nettype none
module ccp_pwm_mode_unit_assertions
    import ccp_pwm_pkg::*;
#(
    parameter int CMP_W = 16
) (
    // clock and reset
    input wire logic              mclk,
    input wire logic              arst_n,
    // apb slave
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    input wire logic [DATA_W-1:0] prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    // system and pins
    input wire logic              sleep,
    input wire logic [CMP_W-1:0]  cmp_timer,
    input wire logic              capture_pin,
    input wire logic              unit_output_pin,
    input wire logic              unit_output_oe,
    input wire logic              unit_match_flag,
    input wire logic              conv_trigger
);
    logic flag_clr;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);

    // writing one to the flag bit is the only way the flag may drop
    assign flag_clr = pready && pwrite && paddr == OFF_STATUS && pwdata[STAT_FLAG_POS];

    sequence s_wait_state;
        psel && penable && !pready;
    endsequence
    sequence s_dir_write;
        pready && pwrite && paddr == OFF_PIN_CONFIG;
    endsequence

    a_ready_one_wait: assert property (s_wait_state |=> pready)
        else $error("ready missing after the wait state");
    a_ready_in_access: assert property (pready |-> psel && penable && $past(psel && penable && !pready))
        else $error("ready outside a waited access");
    a_err_needs_ready: assert property (pslverr |-> pready && paddr > OFF_PIN_CONFIG)
        else $error("error without an unmapped access");
    a_unmapped_err: assert property (pready && paddr > OFF_PIN_CONFIG |-> pslverr && prdata == '0)
        else $error("unmapped access not refused");
    a_rdata_idle: assert property (!pready |-> prdata == '0)
        else $error("read data outside the answer cycle");
    a_oe_follows_dir: assert property (s_dir_write |-> ##2 unit_output_oe == !$past(pwdata[PCFG_DIR_POS], 2))
        else $error("output enable does not follow direction bit");
    a_trig_pulse: assert property (conv_trigger |=> !conv_trigger && unit_match_flag)
        else $error("trigger not a single pulse with flag");
    a_flag_sticky: assert property (unit_match_flag && !flag_clr |=> unit_match_flag)
        else $error("match flag dropped without a clear");
    a_pin_sleep_hold: assert property (sleep && $past(sleep) && $past(sleep, 2) |-> $stable(unit_output_pin))
        else $error("output pin moved while asleep");
endmodule : ccp_pwm_mode_unit_assertions

bind ccp_pwm_mode_unit ccp_pwm_mode_unit_assertions #(.CMP_W(CMP_W)) chk_i (
    .mclk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .sleep, .cmp_timer, .capture_pin, .unit_output_pin, .unit_output_oe,
    .unit_match_flag, .conv_trigger
);
`default_nettype wire

// ==== ccp_load_model.sv ====
// load on the unit output pin: measures pulse width and period
`default_nettype none
module ccp_load_model (
    // pin side
    input  wire logic mclk,
    input  wire logic pin,
    input  wire logic oe,
    // measurements
    output var  int   hi_len,
    output var  int   per_len,
    output var  int   rises,
    output var  int   falls
);
    timeunit 1ns;
    timeprecision 1ps;
    logic line;
    logic prev = 1'b0;
    int   cnt  = 0;
    int   hi   = 0;

    // the load pulls an undriven pin low
    assign line = oe ? pin : 1'b0;

    initial begin
        hi_len = 0;
        per_len = 0;
        rises = 0;
        falls = 0;
    end

    // outputs move by nba so the bench never races the count
    always @(posedge mclk) begin
        if (line && !prev) begin
            rises   <= rises + 1;
            per_len <= cnt;
            cnt = 1;
            hi = 1;
        end else begin
            cnt = cnt + 1;
            hi = hi + int'(line);
        end
        if (!line && prev) begin
            falls  <= falls + 1;
            hi_len <= hi;
        end
        prev = line;
    end
endmodule : ccp_load_model
`default_nettype wire

// ==== tb_top.sv ====
// self-checking bench for the modulation unit
`default_nettype none
module tb_top;
    import ccp_pwm_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic              mclk = 1'b0;
    logic              arst_n = 1'b0;
    logic              psel = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = 8'h00;
    logic [DATA_W-1:0] pwdata = 32'h0;
    logic [DATA_W-1:0] prdata;
    logic              pready;
    logic              pslverr;
    logic              sleep = 1'b0;
    logic [15:0]       cmp_timer = 16'h0;
    logic              capture_pin = 1'b0;
    logic              unit_output_pin;
    logic              unit_output_oe;
    logic              unit_match_flag;
    logic              conv_trigger;
    logic [31:0]       rd;
    logic              er;
    int                hi_len, per_len, rises, falls, r0, f0, t0, d, dprev;
    int                errors = 0;
    int                comparisons = 0;
    int                trig_seen = 0;
    logic [7:0]        rst_exp [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h01};
    unit_mode_t        cmp_mode [5] = '{MODE_CMP_SET, MODE_CMP_CLEAR, MODE_CMP_TOGGLE,
                                        MODE_CMP_SOFT, MODE_CMP_TRIG};
    logic              cmp_pin [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
    unit_mode_t        cap_mode [4] = '{MODE_CAPT_FALL, MODE_CAPT_RISE, MODE_CAPT_RISE4,
                                        MODE_CAPT_RISE16};
    int                cap_n [4] = '{1, 1, 4, 16};

    always #2.5 mclk = ~mclk;
    always @(posedge mclk) if (conv_trigger === 1'b1) trig_seen <= trig_seen + 1;

    ccp_pwm_mode_unit #(.CMP_W(16)) ccp_pwm_mode_unit_i (
        .mclk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .sleep, .cmp_timer, .capture_pin, .unit_output_pin, .unit_output_oe,
        .unit_match_flag, .conv_trigger
    );
    ccp_load_model ccp_load_model_i (
        .mclk, .pin(unit_output_pin), .oe(unit_output_oe), .hi_len, .per_len, .rises, .falls
    );

    task automatic results();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : results

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask : cyc

    // an edge first, so a release and the next request never share a time step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rdv, output logic e);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdv = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            errors++;
            results();
        end
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        apb(1'b1, a, wd, rd, er);
    endtask : wr

    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, rd, er);
        check(nm, rd, exp);
    endtask : rchk

    task automatic wait_rises(input int n);
        int k;
        k = rises + n;
        for (int i = 0; rises < k; i++) begin
            if (i == 20000) begin
                errors++;
                results();
            end
            @(posedge mclk);
        end
    endtask : wait_rises

    initial begin
        void'($urandom(32'h0a8162f8));
        cyc(2);
        arst_n <= 1'b1;
        foreach (rst_exp[i]) rchk("reset", 8'(4 * i), 32'(rst_exp[i]));
        check("oe", unit_output_oe, 32'h0);
        apb(1'b0, 8'h24, 32'h0, rd, er);
        check("err", er, 32'h1);
        check("err_rd", rd, 32'h0);
        apb(1'b1, 8'h40, 32'hff, rd, er);
        check("err_wr", er, 32'h1);
        $display("test reset done");
        dprev = 0;
        wr(OFF_PIN_CONFIG, 32'h0);
        wr(OFF_PERIOD_LIMIT, 32'h3);
        for (int p = 0; p < 3; p++) begin
            d = 1 + $urandom % 15;
            wr(OFF_TIMER_CONTROL, 32'h0);
            wr(OFF_DUTY_BYTE, 32'(d >> 2));
            wr(OFF_UNIT_CONTROL, 32'((d % 4) << 4 | 12));
            rchk("held", OFF_ACTIVE_DUTY, 32'(dprev >> 2));
            // postscale is random and must not move the period
            wr(OFF_TIMER_CONTROL, 32'((($urandom % 16) << 3) | 4 | p));
            wait_rises(3);
            check("period", per_len, 32'(16 << 2 * p));
            check("width", hi_len, 32'(d << 2 * p));
            wr(OFF_ACTIVE_DUTY, 32'h0);
            rchk("buffer", OFF_ACTIVE_DUTY, 32'(d >> 2));
            dprev = d;
        end
        wr(OFF_TIMER_CONTROL, 32'h4);
        wr(OFF_UNIT_CONTROL, 32'hc);
        wr(OFF_DUTY_BYTE, 32'h0);
        cyc(40);
        r0 = rises;
        cyc(64);
        check("no_rise", rises, r0);
        wr(OFF_DUTY_BYTE, 32'h5);
        cyc(40);
        f0 = falls;
        cyc(64);
        check("no_fall", falls, f0);
        check("stuck_hi", unit_output_pin, 32'h1);
        wr(OFF_DUTY_BYTE, 32'h2);
        wait_rises(2);
        sleep <= 1'b1;
        cyc(40);
        sleep <= 1'b0;
        wait_rises(1);
        check("sleep", per_len, 32'd56);
        wait_rises(2);
        check("wake", per_len, 32'd16);
        $display("test pwm done");
        wr(OFF_UNIT_CONTROL, 32'h0);
        cyc(3);
        check("off", unit_output_pin, 32'h0);
        wr(OFF_PIN_CONFIG, 32'h2);
        wr(OFF_ACTIVE_DUTY, 32'h12);
        wr(OFF_DUTY_BYTE, 32'h34);
        foreach (cmp_mode[i]) begin
            wr(OFF_UNIT_CONTROL, 32'(cmp_mode[i]));
            wr(OFF_STATUS, 32'h1);
            t0 = trig_seen;
            cmp_timer <= 16'h1234;
            cyc(1);
            for (int k = 0; k < 20 && unit_match_flag !== 1'b1; k++) cyc(1);
            cmp_timer <= 16'h0;
            cyc(3);
            check("flag", unit_match_flag, 32'h1);
            if (unit_match_flag !== 1'b1) results();
            check("pin", unit_output_pin, 32'(cmp_pin[i]));
            check("trig", trig_seen - t0, 32'(i == 4));
        end
        $display("test compare done");
        foreach (cap_mode[i]) begin
            wr(OFF_UNIT_CONTROL, 32'h0);
            wr(OFF_DUTY_BYTE, 32'h0);
            wr(OFF_UNIT_CONTROL, 32'(cap_mode[i]));
            for (int k = 1; k <= cap_n[i]; k++) begin
                if (k == cap_n[i]) rchk("early", OFF_DUTY_BYTE, 32'h0);
                cmp_timer <= 16'(k);
                capture_pin <= 1'b1;
                cyc(8);
                capture_pin <= 1'b0;
                cyc(8);
            end
            rchk("capture", OFF_DUTY_BYTE, 32'(cap_n[i]));
        end
        $display("test capture done");
        results();
    end
endmodule : tb_top
`default_nettype wire
